// *** hdl/byte_lane_serializer.sv ***
`timescale 1ns/1ps

module byte_lane_serializer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [31:0] word_i,
   input wire logic [1:0] lane_i,
   input wire logic [2:0] count_i,
   input wire logic last_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [7:0] data_o,
   output logic last_o
);

   logic [31:0] word_reg;
   logic [2:0] cnt_reg;
   logic last_reg;

   assign data_o = word_reg[7:0];

   // Emits count_i bytes of a dword, starting at byte lane lane_i.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_reg <= 32'h0000_0000;
         cnt_reg <= 3'h0;
         last_reg <= 1'b0;
         valid_o <= 1'b0;
         last_o <= 1'b0;
      end else if (load_i) begin
         word_reg <= word_i >> {lane_i, 3'h0};
         cnt_reg <= count_i;
         last_reg <= last_i;
         valid_o <= (count_i != 3'h0);
         last_o <= last_i && (count_i == 3'h1);
      end else if (valid_o && ready_i) begin
         word_reg <= {8'h00, word_reg[31:8]};
         cnt_reg <= cnt_reg - 3'h1;
         valid_o <= (cnt_reg != 3'h1);
         last_o <= last_reg && (cnt_reg == 3'h2);
      end
   end

endmodule

// *** hdl/crc32_byte_unit.sv ***
`timescale 1ns/1ps

module crc32_byte_unit
   import gather_dma_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic init_i,
   input wire logic update_i,
   input wire logic [7:0] data_i,
   output logic [31:0] crc_o
);

   logic [31:0] crc_next;

   // Reflected CRC-32, one byte per update, least significant bit first.
   always_comb begin
      crc_next = crc_o;
      for (int i = 0; i < 8; i++) begin
         if (crc_next[0] ^ data_i[i]) begin
            crc_next = (crc_next >> 1) ^ CRC_POLY;
         end else begin
            crc_next = crc_next >> 1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || init_i) begin
         crc_o <= CRC_INIT;
      end else if (update_i) begin
         crc_o <= crc_next;
      end
   end

endmodule

// *** hdl/gather_dma.sv ***
`timescale 1ns/1ps

// Summary of operation
// - Start fetching at the list head descriptor.
// - Fetch block address and length pairwise.
// - Descriptors span 16 to 512 bytes.
// - At most 63 blocks per descriptor.
// - First dword links onward; zero ends list.
// - Suppress bit set: no checksum appended.
// - Suppress bit clear: append computed checksum.
// - Underrun: bad checksum or abort delimiter.
// - Set transfer done flag after all blocks.
// - Send request bit: interrupt after transmission.
// - No send interrupt unless error, otherwise.
// - Skip bit: move no data, follow link.
// - Done request bit: interrupt when download ends.
// - Read header before and after the transfer.
// - All pointers are physical addresses.
// - Block address starts one contiguous data block.
// - Length field and final block flag.
// - Blocks may start on any byte.
// - Start only with head nonzero, no hold, underrun.

module gather_dma
   import gather_dma_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   output logic tx_abort_o,
   input wire logic tx_underrun_i,
   input wire logic tx_done_i,
   input wire logic tx_error_i,
   output logic transfer_done_irq_o,
   output logic send_done_interrupt_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   state_t state_reg;
   logic [31:0] list_head_pointer_reg;
   logic engine_hold_state_reg;
   logic bad_crc_enable_reg;
   logic underrun_reg;
   logic [31:0] next_descriptor_link_reg;
   logic [31:0] header_word_reg;
   logic [31:0] fresh_header_reg;
   logic [31:0] block_addr_reg;
   logic [14:0] remaining_reg;
   logic final_block_flag_reg;
   logic [5:0] block_count_reg;
   logic [8:0] entry_ofs_reg;
   logic [2:0] chunk_reg;
   logic check_loaded_reg;
   logic send_pending_reg;
   logic [31:0] fetch_addr;
   logic mem_done;
   logic wb_hit;
   logic start_ok;
   logic [2:0] lane_room;
   logic [2:0] chunk;
   logic ser_load;
   logic [31:0] ser_word;
   logic [1:0] ser_lane;
   logic [2:0] ser_count;
   logic ser_last;
   logic [31:0] crc_value;
   logic crc_init;
   logic crc_update;
   logic suppress_checksum;
   state_t after_block;

   assign mem_done = mem_req_o && mem_ack_i;
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign suppress_checksum = header_word_reg[HDR_SUPPRESS_BIT];

   assign start_ok = (list_head_pointer_reg != 32'h0000_0000) &&
                     !engine_hold_state_reg && !underrun_reg;

   assign lane_room = 3'h4 - {1'b0, block_addr_reg[1:0]};
   assign chunk = ({12'h000, lane_room} > remaining_reg) ?
                  remaining_reg[2:0] : lane_room;

   // ----------------------------------------------------------------
   // Descriptor and data block fetch addresses
   // ----------------------------------------------------------------
   always_comb begin
      case (state_reg)
         ST_RD_NEXT: fetch_addr = list_head_pointer_reg +
                                  {23'h000000, DESC_NEXT_OFS};
         ST_RD_HDR, ST_RD_HDR2, ST_WR_HDR:
            fetch_addr = list_head_pointer_reg + {23'h000000, DESC_HDR_OFS};
         ST_RD_ADDR, ST_RD_LEN:
            fetch_addr = list_head_pointer_reg + {23'h000000, entry_ofs_reg};
         ST_RD_DATA: fetch_addr = {block_addr_reg[31:2], 2'h0};
         default: fetch_addr = 32'h0000_0000;
      endcase
   end

   // After a block, either fetch another pair or close the packet.
   always_comb begin
      if (!final_block_flag_reg) begin
         after_block = ST_RD_ADDR;
      end else if (suppress_checksum) begin
         after_block = ST_RD_HDR2;
      end else begin
         after_block = ST_SEND_CHECK;
      end
   end

   // ----------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= 32'h0000_0000;
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               ADDR_LIST_HEAD: wb_dat_o <= list_head_pointer_reg;
               ADDR_CONTROL: begin
                  wb_dat_o[CTRL_HOLD_BIT] <= engine_hold_state_reg;
                  wb_dat_o[CTRL_BAD_CRC_BIT] <= bad_crc_enable_reg;
               end
               ADDR_STATUS: begin
                  wb_dat_o[STAT_BUSY_BIT] <= (state_reg != ST_IDLE);
                  wb_dat_o[STAT_UNDERRUN_BIT] <= underrun_reg;
                  wb_dat_o[STAT_COUNT_LSB +: 6] <= block_count_reg;
               end
               ADDR_HEADER: wb_dat_o <= header_word_reg;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         engine_hold_state_reg <= CONTROL_RESET[CTRL_HOLD_BIT];
         bad_crc_enable_reg <= CONTROL_RESET[CTRL_BAD_CRC_BIT];
      end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_CONTROL &&
                   wb_sel_i[0]) begin
         engine_hold_state_reg <= wb_dat_i[CTRL_HOLD_BIT];
         bad_crc_enable_reg <= wb_dat_i[CTRL_BAD_CRC_BIT];
      end
   end

   // Underrun is sticky; a new underrun wins over a write-one clear.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         underrun_reg <= 1'b0;
      end else if (tx_underrun_i && state_reg != ST_IDLE) begin
         underrun_reg <= 1'b1;
      end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_STATUS &&
                   wb_sel_i[0] && wb_dat_i[STAT_UNDERRUN_BIT]) begin
         underrun_reg <= 1'b0;
      end
   end

   // The head is written by software only while idle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         list_head_pointer_reg <= LIST_HEAD_RESET;
      end else if (state_reg == ST_ADVANCE) begin
         list_head_pointer_reg <= next_descriptor_link_reg;
      end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_LIST_HEAD &&
                   state_reg == ST_IDLE) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               list_head_pointer_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Host memory master
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h0000_0000;
         mem_wdata_o <= 32'h0000_0000;
      end else if (mem_done) begin
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
      end else if (!mem_req_o) begin
         case (state_reg)
            ST_RD_NEXT, ST_RD_HDR, ST_RD_ADDR, ST_RD_LEN, ST_RD_DATA,
            ST_RD_HDR2: begin
               mem_req_o <= 1'b1;
               mem_we_o <= 1'b0;
               mem_addr_o <= fetch_addr;
            end
            ST_WR_HDR: begin
               mem_req_o <= 1'b1;
               mem_we_o <= 1'b1;
               mem_addr_o <= fetch_addr;
               mem_wdata_o <= fresh_header_reg |
                              (32'h0000_0001 << HDR_DONE_BIT);
            end
            default: mem_req_o <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Descriptor walker
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         next_descriptor_link_reg <= 32'h0000_0000;
         header_word_reg <= 32'h0000_0000;
         fresh_header_reg <= 32'h0000_0000;
         block_addr_reg <= 32'h0000_0000;
         remaining_reg <= 15'h0000;
         final_block_flag_reg <= 1'b0;
         block_count_reg <= 6'h00;
         entry_ofs_reg <= DESC_FIRST_BLOCK_OFS;
         chunk_reg <= 3'h0;
         check_loaded_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               block_count_reg <= 6'h00;
               entry_ofs_reg <= DESC_FIRST_BLOCK_OFS;
               check_loaded_reg <= 1'b0;
               if (start_ok) begin
                  state_reg <= ST_RD_NEXT;
               end
            end
            ST_RD_NEXT: if (mem_done) begin
               next_descriptor_link_reg <= mem_rdata_i;
               state_reg <= ST_RD_HDR;
            end
            ST_RD_HDR: if (mem_done) begin
               header_word_reg <= mem_rdata_i;
               state_reg <= mem_rdata_i[HDR_SKIP_BIT] ? ST_ADVANCE :
                            ST_RD_ADDR;
            end
            ST_RD_ADDR: if (mem_done) begin
               block_addr_reg <= mem_rdata_i;
               entry_ofs_reg <= entry_ofs_reg + DESC_ENTRY_STEP;
               state_reg <= ST_RD_LEN;
            end
            ST_RD_LEN: if (mem_done) begin
               remaining_reg <= mem_rdata_i[HDR_LEN_MSB:0];
               final_block_flag_reg <= mem_rdata_i[LEN_FINAL_BIT] ||
                  (block_count_reg == MAX_BLOCKS - 6'h01);
               block_count_reg <= block_count_reg + 6'h01;
               entry_ofs_reg <= entry_ofs_reg + DESC_ENTRY_STEP;
               if (mem_rdata_i[HDR_LEN_MSB:0] != 15'h0000) begin
                  state_reg <= ST_RD_DATA;
               end else if (mem_rdata_i[LEN_FINAL_BIT] ||
                            block_count_reg == MAX_BLOCKS - 6'h01) begin
                  state_reg <= suppress_checksum ? ST_RD_HDR2 :
                               ST_SEND_CHECK;
               end else begin
                  state_reg <= ST_RD_ADDR;
               end
            end
            ST_RD_DATA: if (mem_done) begin
               chunk_reg <= chunk;
               state_reg <= ST_SEND_DATA;
            end
            ST_SEND_DATA: if (!tx_valid_o) begin
               block_addr_reg <= block_addr_reg + {29'h0, chunk_reg};
               remaining_reg <= remaining_reg - {12'h000, chunk_reg};
               if (underrun_reg) begin
                  state_reg <= bad_crc_enable_reg ? ST_SEND_CHECK : ST_IDLE;
               end else if (remaining_reg == {12'h000, chunk_reg}) begin
                  state_reg <= after_block;
               end else begin
                  state_reg <= ST_RD_DATA;
               end
            end
            ST_SEND_CHECK: begin
               check_loaded_reg <= 1'b1;
               if (check_loaded_reg && !tx_valid_o) begin
                  state_reg <= underrun_reg ? ST_IDLE : ST_RD_HDR2;
               end
            end
            ST_RD_HDR2: if (mem_done) begin
               fresh_header_reg <= mem_rdata_i;
               state_reg <= ST_WR_HDR;
            end
            ST_WR_HDR: if (mem_done) begin
               state_reg <= ST_ADVANCE;
            end
            ST_ADVANCE: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Transmit byte stream and checksum
   // ----------------------------------------------------------------
   always_comb begin
      ser_load = 1'b0;
      ser_word = mem_rdata_i;
      ser_lane = block_addr_reg[1:0];
      ser_count = chunk;
      ser_last = final_block_flag_reg && suppress_checksum &&
                 (remaining_reg == {12'h000, chunk});
      if (state_reg == ST_RD_DATA) begin
         ser_load = mem_done;
      end else if (state_reg == ST_SEND_CHECK && !check_loaded_reg) begin
         ser_load = 1'b1;
         ser_lane = 2'h0;
         ser_count = 3'h4;
         ser_last = 1'b1;
         ser_word = ~crc_value;
         if (underrun_reg) begin
            ser_word = crc_value;
         end
      end
   end

   assign crc_init = (state_reg == ST_IDLE);
   assign crc_update = (state_reg == ST_SEND_DATA) && tx_valid_o &&
                       tx_ready_i;

   crc32_byte_unit u_crc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .init_i(crc_init),
      .update_i(crc_update),
      .data_i(tx_data_o),
      .crc_o(crc_value)
   );

   byte_lane_serializer u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(ser_load),
      .word_i(ser_word),
      .lane_i(ser_lane),
      .count_i(ser_count),
      .last_i(ser_last),
      .ready_i(tx_ready_i),
      .valid_o(tx_valid_o),
      .data_o(tx_data_o),
      .last_o(tx_last_o)
   );

   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_abort_o <= 1'b0;
      end else begin
         tx_abort_o <= (state_reg == ST_SEND_DATA) && !tx_valid_o &&
                       underrun_reg && !bad_crc_enable_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         transfer_done_irq_o <= 1'b0;
      end else begin
         transfer_done_irq_o <= (state_reg == ST_WR_HDR) && mem_done &&
                                fresh_header_reg[HDR_DONE_IRQ_BIT];
      end
   end

   // A new pending request wins over the completion that retires it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         send_pending_reg <= 1'b0;
         send_done_interrupt_o <= 1'b0;
      end else begin
         send_done_interrupt_o <= tx_done_i &&
                                  (send_pending_reg || tx_error_i);
         if ((state_reg == ST_WR_HDR) && mem_done) begin
            send_pending_reg <= header_word_reg[HDR_SEND_IRQ_BIT];
         end else if (tx_done_i) begin
            send_pending_reg <= 1'b0;
         end
      end
   end

endmodule

// *** hdl/gather_dma_pkg.sv ***
package gather_dma_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses on the register bus
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_LIST_HEAD = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_HEADER = 8'h0c;

   localparam int CTRL_HOLD_BIT = 0;
   localparam int CTRL_BAD_CRC_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_UNDERRUN_BIT = 1;
   localparam int STAT_COUNT_LSB = 8;

   localparam logic [31:0] LIST_HEAD_RESET = 32'h0000_0000;
   localparam logic [1:0] CONTROL_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Descriptor layout
   // ----------------------------------------------------------------
   localparam logic [8:0] DESC_NEXT_OFS = 9'h000;
   localparam logic [8:0] DESC_HDR_OFS = 9'h004;
   localparam logic [8:0] DESC_FIRST_BLOCK_OFS = 9'h008;
   localparam logic [8:0] DESC_ENTRY_STEP = 9'h004;
   localparam logic [5:0] MAX_BLOCKS = 6'h3f;

   localparam int HDR_LEN_MSB = 14;
   localparam int HDR_SUPPRESS_BIT = 15;
   localparam int HDR_DONE_BIT = 16;
   localparam int HDR_SEND_IRQ_BIT = 27;
   localparam int HDR_SKIP_BIT = 29;
   localparam int HDR_DONE_IRQ_BIT = 31;
   localparam int LEN_FINAL_BIT = 31;

   // ----------------------------------------------------------------
   // Checksum
   // ----------------------------------------------------------------
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] CRC_POLY = 32'hedb8_8320;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_RD_NEXT = 11'h002,
      ST_RD_HDR = 11'h004,
      ST_RD_ADDR = 11'h008,
      ST_RD_LEN = 11'h010,
      ST_RD_DATA = 11'h020,
      ST_SEND_DATA = 11'h040,
      ST_SEND_CHECK = 11'h080,
      ST_RD_HDR2 = 11'h100,
      ST_WR_HDR = 11'h200,
      ST_ADVANCE = 11'h400
   } state_t;

endpackage

// *** tb/gather_dma_props.sv ***
`timescale 1ns/1ps
module gather_dma_props
   import gather_dma_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic [31:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic tx_done_i,
   input wire logic tx_error_i,
   input wire logic transfer_done_irq_o,
   input wire logic send_done_interrupt_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_req_holds: assert property (mem_req_o && !mem_ack_i |=>
      mem_req_o && $stable(mem_addr_o)) else $error("request dropped");
   a_req_gap: assert property (mem_req_o && mem_ack_i |=>
      !mem_req_o) else $error("no idle after ack");
   a_addr_dword: assert property (mem_req_o |->
      mem_addr_o[1:0] == 2'h0) else $error("unaligned fetch");
   a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o)) else $error("byte lost");
   a_done_written: assert property (mem_req_o && mem_we_o |->
      mem_wdata_o[HDR_DONE_BIT]) else $error("done flag not set");
   a_irq_cause: assert property (transfer_done_irq_o |->
      $past(mem_ack_i && mem_we_o)) else $error("stray done irq");
   a_irq_pulse: assert property (transfer_done_irq_o |=>
      !transfer_done_irq_o) else $error("done irq too long");
   a_send_cause: assert property (send_done_interrupt_o |->
      $past(tx_done_i)) else $error("stray send irq");
   a_error_irq: assert property (tx_done_i && tx_error_i |=>
      send_done_interrupt_o) else $error("error gave no irq");
endmodule

bind gather_dma gather_dma_props gather_dma_props_inst (
   .clk_i(clk_i), .rst_i(rst_i), .mem_req_o(mem_req_o),
   .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
   .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
   .tx_ready_i(tx_ready_i), .tx_done_i(tx_done_i),
   .tx_error_i(tx_error_i), .transfer_done_irq_o(transfer_done_irq_o),
   .send_done_interrupt_o(send_done_interrupt_o));

// *** tb/host_mem_model.sv ***
`timescale 1ns/1ps
module host_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:255];
   logic [1:0] wait_reg;
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (rst_i) begin
         wait_reg <= 2'h0;
         rdata_o <= 32'h0;
      end else if (req_i && !ack_o) begin
         wait_reg <= wait_reg + 2'h1;
         if (!slow_i || wait_reg == 2'h3) begin
            wait_reg <= 2'h0;
            ack_o <= 1'b1;
            rdata_o <= mem[addr_i[9:2]];
            if (we_i) mem[addr_i[9:2]] <= wdata_i;
         end
      end
   end
endmodule

// *** tb/tb_gather_dma.sv ***
`timescale 1ns/1ps
module tb_gather_dma;
   import gather_dma_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, tx_data_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_addr_o, mem_wdata_o;
   logic [31:0] mem_rdata_i;
   logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, tx_valid_o, tx_last_o;
   logic tx_ready_i = 1'b0, tx_done_i = 1'b0, tx_error_i = 1'b0;
   logic done_irq, send_irq, abort, under = 1'b0;
   int error_cnt = 0, checks = 0, n_done = 0, n_send = 0, n_abort = 0;
   logic [8:0] rx_q[$];
   logic [31:0] adr_q[$];
   always #5 clk_i = ~clk_i;
   gather_dma gather_dma_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
      .tx_ready_i(tx_ready_i), .tx_abort_o(abort), .tx_underrun_i(under),
      .tx_done_i(tx_done_i), .tx_error_i(tx_error_i),
      .transfer_done_irq_o(done_irq), .send_done_interrupt_o(send_irq));
   host_mem_model host_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
      .rdata_o(mem_rdata_i));
   always @(posedge clk_i) begin
      tx_ready_i <= ~tx_ready_i;
      if (tx_valid_o && tx_ready_i) rx_q.push_back({tx_last_o, tx_data_o});
      if (mem_req_o && mem_ack_i) adr_q.push_back(mem_addr_o);
      if (done_irq) n_done++;
      if (send_irq) n_send++;
      if (abort) n_abort++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic put(input int a, input logic [7:0] v);
      host_mem_model_inst.mem[a/4][8*(a%4) +: 8] = v;
   endtask
   task automatic wait_done(input int n);
      for (int t = 0; t < 3000 && n_done < n; t++) @(posedge clk_i);
      repeat (30) @(posedge clk_i);
   endtask
   task automatic pulse_done(input logic err);
      @(posedge clk_i);
      tx_done_i <= 1'b1;
      tx_error_i <= err;
      @(posedge clk_i);
      tx_done_i <= 1'b0;
      tx_error_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic chk_rx(input logic [7:0] d[$], input logic add);
      logic [31:0] c;
      c = CRC_INIT;
      foreach (d[i]) begin
         c ^= {24'h0, d[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      c = ~c;
      if (add) for (int i = 0; i < 4; i++) d.push_back(c[8*i +: 8]);
      chk(rx_q.size(), d.size());
      foreach (d[i]) chk(rx_q[i], {i == d.size() - 1, d[i]});
      rx_q.delete();
   endtask
   task automatic s_hold();
      logic [31:0] q;
      logic [7:0] d[$];
      host_mem_model_inst.mem[8'h10] = 32'h0;
      host_mem_model_inst.mem[8'h11] = 32'h8800_0005;
      host_mem_model_inst.mem[8'h12] = 32'h0000_0101;
      host_mem_model_inst.mem[8'h13] = 32'h8000_0005;
      for (int i = 0; i < 5; i++) d.push_back(8'ha0 + i);
      foreach (d[i]) put(32'h101 + i, d[i]);
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, ADDR_CONTROL, 32'h1, q);
      wb(1'b1, ADDR_LIST_HEAD, 32'h40, q);
      repeat (20) @(posedge clk_i);
      chk(adr_q.size(), 0);
      wb(1'b1, ADDR_CONTROL, 32'h0, q);
      wait_done(1);
      chk(adr_q[0], 32'h40);
      chk({adr_q[1], adr_q[2], adr_q[3]}, {32'h44, 32'h48, 32'h4c});
      chk(adr_q[$], 32'h44);
      chk_rx(d, 1'b1);
      chk(host_mem_model_inst.mem[8'h11][16], 1'b1);
      wb(1'b0, ADDR_LIST_HEAD, 32'h0, q);
      chk(q, 32'h0);
      pulse_done(1'b0);
      chk(n_send, 1);
   endtask
   task automatic s_chain();
      logic [31:0] q;
      logic [7:0] d[$];
      host_mem_model_inst.mem[8'h20] = 32'h0000_00c0;
      host_mem_model_inst.mem[8'h21] = 32'h2000_0000;
      host_mem_model_inst.mem[8'h30] = 32'h0;
      host_mem_model_inst.mem[8'h31] = 32'h0000_8006;
      host_mem_model_inst.mem[8'h32] = 32'h0000_0203;
      host_mem_model_inst.mem[8'h33] = 32'h0000_0002;
      host_mem_model_inst.mem[8'h34] = 32'h0000_0210;
      host_mem_model_inst.mem[8'h35] = 32'h8000_0004;
      for (int i = 0; i < 6; i++) d.push_back(8'hb0 + i);
      put(32'h203, d[0]);
      put(32'h204, d[1]);
      for (int i = 2; i < 6; i++) put(32'h20e + i, d[i]);
      adr_q.delete();
      slow = 1'b1;
      wb(1'b1, ADDR_LIST_HEAD, 32'h80, q);
      for (int t = 0; t < 2000 && rx_q.size() == 0; t++) @(posedge clk_i);
      @(negedge clk_i);
      host_mem_model_inst.mem[8'h31][31] = 1'b1;
      wait_done(2);
      chk(n_done, 2);
      chk(adr_q[2], 32'hc0);
      chk(host_mem_model_inst.mem[8'h21][16], 1'b0);
      chk(host_mem_model_inst.mem[8'h31][16], 1'b1);
      chk_rx(d, 1'b0);
      pulse_done(1'b0);
      chk(n_send, 1);
      pulse_done(1'b1);
      chk(n_send, 2);
   endtask
   task automatic s_underrun();
      logic [31:0] q;
      wb(1'b1, ADDR_LIST_HEAD, 32'hc0, q);
      for (int t = 0; t < 2000 && rx_q.size() == 0; t++) @(posedge clk_i);
      under <= 1'b1;
      @(posedge clk_i);
      under <= 1'b0;
      for (int t = 0; t < 500 && n_abort == 0; t++) @(posedge clk_i);
      chk(n_abort, 1);
      wb(1'b0, ADDR_STATUS, 32'h0, q);
      chk(q[1:0], 2'h2);
      wb(1'b0, ADDR_LIST_HEAD, 32'h0, q);
      chk(q, 32'hc0);
      rx_q.delete();
      wb(1'b1, ADDR_STATUS, 32'h2, q);
      wait_done(3);
      chk(rx_q.size(), 6);
   endtask
   task automatic end_sim();
      $display("error_cnt %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      s_hold();
      s_chain();
      s_underrun();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      end_sim();
   end
endmodule
